// >>> rtl/card_port_regs.svh
`ifndef CARD_PORT_REGS_SVH
`define CARD_PORT_REGS_SVH
// ************************************************************
// address decode and status change bit positions
// ************************************************************
`define ADDR_W          11
`define IDE_ADDR_W      3
`define ATTR_CFG_BASE   11'h200
`define CSR_CHG_POS     6
`define CSR_RDY_POS     5
`define CSR_WP_POS      4
`endif

// >>> rtl/card_port_pkg.sv
package card_port_pkg;
    typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_IDE} if_mode_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_IO_PORT, SEL_MEM_PORT, SEL_CIS, SEL_CFG,
                              SEL_TASK, SEL_ALT} target_t;
    typedef enum {DMA_IDLE, DMA_REQ, DMA_ACKED} dma_state_t;
endpackage : card_port_pkg

// >>> rtl/card_port.sv
`timescale 1ns/1ps
`include "card_port_regs.svh"
module card_port
    import card_port_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                NRST,
    input  wire logic [1:0]          MODE,
    input  wire logic [`ADDR_W-1:0]  ADDR,
    input  wire logic                REG_N,
    input  wire logic                CE1_N,
    input  wire logic                CE2_N,
    input  wire logic                IORD_N,
    input  wire logic                IOWR_N,
    input  wire logic                DMACK_N,
    input  wire logic                DMA_EN,
    input  wire logic                DEV_SEL,
    input  wire logic                DMA_PENDING,
    input  wire logic                CARD_READY,
    input  wire logic                CARD_WP,
    input  wire logic [7:0]          CFG_CSR,
    input  wire logic [15:0]         RD_DATA,
    input  wire logic [15:0]         D_IN,
    output logic [15:0]              D_OUT,
    output logic [15:0]              D_OE,
    output logic [15:0]              WR_DATA,
    output logic [1:0]               WR_LANES,
    output logic [2:0]               TARGET,
    output logic [`ADDR_W-1:0]       REG_ADDR,
    output logic                     BATT1,
    output logic                     BATT2,
    output logic                     BATT_OE,
    output logic                     STSCHG_N,
    output logic                     STSCHG_OE,
    output logic                     SPKR_N,
    output logic                     SPKR_OE,
    output logic                     INPACK_N,
    output logic                     DMARQ,
    output logic                     DMARQ_OE
);
    // ************************************************************
    // session mode
    // ************************************************************
    if_mode_t   mode_r;
    logic       mode_ok_r;
    logic       ide, io_m, mem_m;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            mode_ok_r <= 1'b0;
            mode_r    <= MODE_MEM;
        end else if (!mode_ok_r) begin
            mode_ok_r <= 1'b1;
            mode_r    <= (MODE == 2'h2) ? MODE_IDE : (MODE == 2'h1) ? MODE_IO : MODE_MEM;
        end
    end
    assign ide   = mode_ok_r && mode_r == MODE_IDE;
    assign io_m  = mode_ok_r && mode_r == MODE_IO;
    assign mem_m = mode_ok_r && mode_r == MODE_MEM;

    // ************************************************************
    // address decode
    // ************************************************************
    logic    sel, dmack;
    target_t tgt;
    assign dmack = ide && DMA_EN && !DMACK_N;
    assign sel   = !CE1_N || !CE2_N;
    always_comb begin
        tgt = SEL_NONE;
        if (ide) begin
            if (!dmack && !CE1_N) tgt = SEL_TASK;
            else if (!dmack && !CE2_N) tgt = SEL_ALT;
        end else if (mode_ok_r && sel) begin
            if (!REG_N && (!IORD_N || !IOWR_N)) tgt = SEL_IO_PORT;
            else if (REG_N) tgt = SEL_MEM_PORT;
            else if (ADDR < `ATTR_CFG_BASE) tgt = SEL_CIS;
            else tgt = SEL_CFG;
        end
    end
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            TARGET   <= SEL_NONE;
            REG_ADDR <= '0;
        end else begin
            TARGET   <= tgt;
            REG_ADDR <= ide ? {8'h00, ADDR[`IDE_ADDR_W-1:0]} : ADDR;
        end
    end

    // ************************************************************
    // data lanes
    // ************************************************************
    logic rd_act, word_xfer;
    assign rd_act    = !IORD_N && ((tgt != SEL_NONE) || dmack);
    assign word_xfer = ide ? dmack || (tgt == SEL_TASK && ADDR[2:0] == 3'h0)
                           : (!CE1_N && !CE2_N);
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            D_OUT    <= 16'h0000;
            D_OE     <= 16'h0000;
            WR_DATA  <= 16'h0000;
            WR_LANES <= 2'h0;
        end else begin
            if (ide && !word_xfer) begin
                D_OUT <= {8'h00, RD_DATA[7:0]};
                D_OE  <= rd_act ? 16'h00FF : 16'h0000;
            end else if (!ide && !word_xfer && CE1_N && !CE2_N) begin
                D_OUT <= {RD_DATA[15:8], 8'h00};
                D_OE  <= rd_act ? 16'hFF00 : 16'h0000;
            end else if (!ide && !word_xfer && ADDR[0]) begin
                D_OUT <= {8'h00, RD_DATA[15:8]};
                D_OE  <= rd_act ? 16'h00FF : 16'h0000;
            end else begin
                D_OUT <= RD_DATA;
                D_OE  <= rd_act ? (word_xfer ? 16'hFFFF : 16'h00FF) : 16'h0000;
            end
            WR_DATA  <= D_IN;
            if (IOWR_N)
                WR_LANES <= 2'h0;
            else if (word_xfer)
                WR_LANES <= 2'h3;
            else if (!ide && CE1_N && !CE2_N)
                WR_LANES <= 2'h2;
            else
                WR_LANES <= 2'h1;
        end
    end

    // ************************************************************
    // static indications
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            BATT1   <= 1'b1;
            BATT2   <= 1'b1;
            BATT_OE <= 1'b0;
            SPKR_N  <= 1'b1;
            SPKR_OE <= 1'b0;
        end else begin
            BATT1   <= 1'b1;
            BATT2   <= 1'b1;
            BATT_OE <= mem_m;
            SPKR_N  <= 1'b1;
            SPKR_OE <= io_m;
        end
    end

    // ************************************************************
    // status change
    // ************************************************************
    logic rdy_d, wp_d, chg_r;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            // preload the pin levels so reset release shows no false change
            rdy_d <= CARD_READY;
            wp_d  <= CARD_WP;
            chg_r <= 1'b0;
        end else begin
            rdy_d <= CARD_READY;
            wp_d  <= CARD_WP;
            if ((CFG_CSR[`CSR_RDY_POS] && rdy_d != CARD_READY) ||
                (CFG_CSR[`CSR_WP_POS] && wp_d != CARD_WP))
                chg_r <= 1'b1;
            else if (!CFG_CSR[`CSR_CHG_POS])
                chg_r <= 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            STSCHG_N  <= 1'b1;
            STSCHG_OE <= 1'b0;
        end else begin
            STSCHG_N  <= !(chg_r && CFG_CSR[`CSR_CHG_POS]);
            STSCHG_OE <= io_m;
        end
    end

    // ************************************************************
    // input acknowledge
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) INPACK_N <= 1'b1;
        else INPACK_N <= !(io_m && tgt == SEL_IO_PORT && !IORD_N);
    end
    inpack_sel_a: assert property (@(posedge CLK) disable iff (!NRST)
        !INPACK_N |-> $past(io_m && !IORD_N && sel && !REG_N))
        else $error("input acknowledge without selected I/O read");

    // ************************************************************
    // dma handshake
    // ************************************************************
    dma_state_t dma_r;
    always_ff @(posedge CLK) begin
        if (!NRST) dma_r <= DMA_IDLE;
        else if (!ide || !DMA_EN) dma_r <= DMA_IDLE;
        else begin
            unique case (dma_r)
                DMA_IDLE:  if (DMA_PENDING) dma_r <= DMA_REQ;
                DMA_REQ:   if (dmack) dma_r <= DMA_ACKED;
                DMA_ACKED: if (!dmack) dma_r <= DMA_IDLE;
            endcase
        end
    end
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            DMARQ    <= 1'b0;
            DMARQ_OE <= 1'b0;
        end else begin
            DMARQ    <= dma_r == DMA_REQ && !dmack;
            DMARQ_OE <= ide && DEV_SEL;
        end
    end
    dmarq_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
        DMARQ && !dmack && ide && DMA_EN |=> DMARQ)
        else $error("dma request dropped before acknowledge");
    dmarq_float_a: assert property (@(posedge CLK) disable iff (!NRST)
        !DEV_SEL |=> !DMARQ_OE)
        else $error("dma request driven while not selected");
    batt_high_a: assert property (@(posedge CLK) disable iff (!NRST)
        BATT_OE |-> BATT1 && BATT2)
        else $error("battery status not high");
    spkr_high_a: assert property (@(posedge CLK) disable iff (!NRST)
        SPKR_N)
        else $error("audio output low");
    ide_addr_a: assert property (@(posedge CLK) disable iff (!NRST)
        $past(ide) |-> REG_ADDR[`ADDR_W-1:`IDE_ADDR_W] == '0)
        else $error("upper address decoded in ide mode");
    ide_byte_a: assert property (@(posedge CLK) disable iff (!NRST)
        $past(ide && !word_xfer) |-> D_OE[15:8] == 8'h00)
        else $error("task register access not byte wide");
    dmack_ign_a: assert property (@(posedge CLK) disable iff (!NRST)
        !DMA_EN |=> dma_r == DMA_IDLE)
        else $error("acknowledge honoured with dma disabled");
endmodule : card_port

// >>> sim/host_model.sv
`timescale 1ns/1ps
// ************************************************************
// host dma acknowledge
// ************************************************************
module host_model (
    input  wire logic       clk,
    input  wire logic [3:0] dly,
    input  wire logic       dmarq,
    output wire logic       dmack_n
);
    int   cnt   = 0;
    logic ack_r = 1'b1;
    assign dmack_n = ack_r;
    // answers a standing request after dly cycles, then holds acknowledge for two edges
    always @(posedge clk) begin
        #1;
        if (ack_r === 1'b0) begin
            if (cnt >= 1) begin
                ack_r = 1'b1;
                cnt   = 0;
            end else begin
                cnt++;
            end
        end else if (dmarq === 1'b1) begin
            if (cnt >= dly) begin
                ack_r = 1'b0;
                cnt   = 0;
            end else begin
                cnt++;
            end
        end else begin
            cnt = 0;
        end
    end
endmodule : host_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
// ************************************************************
// stimulus and checking
// ************************************************************
module testbench;
    import card_port_pkg::*;
    typedef struct {int due; int sel; logic [15:0] v;} exp_t;
    logic clk = 0, nrst = 0, reg_n = 1, ce1_n = 1, ce2_n = 1, iord_n = 1, iowr_n = 1;
    logic dma_en = 0, dev_sel = 0, pend = 0, dmack_n;
    logic card_ready = 1, card_wp = 0;
    logic [7:0] cfg_csr = 0;
    logic [1:0] mode = 0;
    logic [1:0] wr_lanes;
    logic [10:0] addr = 0, reg_addr;
    logic [15:0] rd_data = 0, d_out, d_oe;
    logic [15:0] d_in = 0, wr_data;
    logic [3:0] dly = 0;
    logic [2:0] target;
    logic batt1, batt2, spkr_n, inpack_n, dmarq, dmarq_oe;
    logic batt_oe, spkr_oe, stschg_n, stschg_oe;
    int err_total = 0, n_checks = 0, cyc = 0, seed = 14614, i, k;
    exp_t q[$];
    string nm[13] = '{"target", "reg_addr", "d_out", "inpack_n", "batt", "spkr_n", "dmarq",
                      "dmarq_oe", "d_oe", "oe_flags", "stschg_n", "wr_data", "wr_lanes"};
    always #4 clk = ~clk;
    card_port i_card_port (.CLK(clk), .NRST(nrst), .MODE(mode), .ADDR(addr), .REG_N(reg_n),
        .CE1_N(ce1_n), .CE2_N(ce2_n), .IORD_N(iord_n), .IOWR_N(iowr_n), .DMACK_N(dmack_n),
        .DMA_EN(dma_en), .DEV_SEL(dev_sel), .DMA_PENDING(pend), .CARD_READY(card_ready),
        .CARD_WP(card_wp), .CFG_CSR(cfg_csr), .RD_DATA(rd_data), .D_IN(d_in), .D_OUT(d_out),
        .D_OE(d_oe), .WR_DATA(wr_data), .WR_LANES(wr_lanes), .TARGET(target),
        .REG_ADDR(reg_addr), .BATT1(batt1), .BATT2(batt2), .BATT_OE(batt_oe),
        .STSCHG_N(stschg_n), .STSCHG_OE(stschg_oe), .SPKR_N(spkr_n), .SPKR_OE(spkr_oe),
        .INPACK_N(inpack_n), .DMARQ(dmarq), .DMARQ_OE(dmarq_oe));
    host_model i_host_model (.clk(clk), .dly(dly), .dmarq(dmarq), .dmack_n(dmack_n));
    function automatic logic [15:0] seen(int s);
        case (s)
            0: seen = {13'h0000, target};
            1: seen = {5'h00, reg_addr};
            2: seen = d_out;
            3: seen = {15'h0000, inpack_n};
            4: seen = {14'h0000, batt1, batt2};
            5: seen = {15'h0000, spkr_n};
            6: seen = {15'h0000, dmarq};
            7: seen = {15'h0000, dmarq_oe};
            8: seen = d_oe;
            9: seen = {13'h0000, batt_oe, spkr_oe, stschg_oe};
            10: seen = {15'h0000, stschg_n};
            11: seen = wr_data;
            default: seen = {14'h0000, wr_lanes};
        endcase
    endfunction : seen
    task automatic expect_v(int s, logic [15:0] v);
        q.push_back('{cyc + 1, s, v});
    endtask : expect_v
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic timed_out;
        err_total++;
        $display("Error wait expected 1 seen 0");
        report_and_stop();
    endtask : timed_out
    task automatic start(logic [1:0] m);
        nrst = 0;
        mode = m;
        repeat (10) step();
        nrst = 1;
        repeat (2) step();
    endtask : start
    // compares every note whose cycle has come, oldest first
    always @(posedge clk) begin
        cyc = cyc + 1;
        #2;
        while (q.size() > 0 && q[0].due <= cyc) begin
            n_checks++;
            if (seen(q[0].sel) !== q[0].v) begin
                err_total++;
                $display("Error %s expected %h seen %h", nm[q[0].sel], q[0].v, seen(q[0].sel));
            end
            void'(q.pop_front());
        end
    end
    initial begin
        start(2'h0);
        {ce1_n, reg_n, iord_n} = 3'h0;
        expect_v(4, 16'h0003);
        expect_v(9, 16'h0004);
        expect_v(3, 16'h0001);
        step();
        {reg_n, iord_n} = 2'h3;
        expect_v(0, 16'h0002);
        step();
        {reg_n, addr} = {1'b0, 11'h1FF};
        expect_v(0, 16'h0003);
        step();
        addr = 11'h200;
        expect_v(0, 16'h0004);
        step();
        {ce1_n, reg_n} = 2'h3;
        start(2'h1);
        dev_sel = 1'b1;
        expect_v(9, 16'h0003);
        expect_v(7, 16'h0000);
        for (i = 0; i < 4; i++) begin
            addr = 11'($random(seed));
            rd_data = 16'($random(seed));
            {ce1_n, ce2_n, reg_n, iord_n} = 4'h0;
            expect_v(0, 16'h0001);
            expect_v(1, {5'h00, addr});
            expect_v(2, rd_data);
            expect_v(3, 16'h0000);
            expect_v(5, 16'h0001);
            expect_v(8, 16'hFFFF);
            step();
            {ce1_n, ce2_n, reg_n, iord_n} = 4'hF;
            expect_v(3, 16'h0001);
            step();
        end
        rd_data = 16'($random(seed));
        d_in = 16'($random(seed));
        {ce1_n, ce2_n, reg_n, iord_n} = 4'h8;
        expect_v(2, {rd_data[15:8], 8'h00});
        expect_v(8, 16'hFF00);
        step();
        {ce1_n, ce2_n, addr} = {2'h1, 11'h001};
        expect_v(2, {8'h00, rd_data[15:8]});
        expect_v(8, 16'h00FF);
        step();
        {ce1_n, ce2_n, iord_n, iowr_n} = 4'hA;
        expect_v(11, d_in);
        expect_v(12, 16'h0002);
        expect_v(3, 16'h0001);
        step();
        {ce2_n, reg_n, iowr_n} = 3'h7;
        {cfg_csr, card_ready} = {8'h60, 1'b0};
        step();
        expect_v(10, 16'h0000);
        step();
        {cfg_csr, card_ready, card_wp} = {8'h40, 2'h3};
        expect_v(10, 16'h0000);
        step();
        cfg_csr = 8'h00;
        expect_v(10, 16'h0001);
        step();
        cfg_csr = 8'h40;
        expect_v(10, 16'h0001);
        step();
        start(2'h2);
        expect_v(9, 16'h0000);
        for (i = 0; i < 6; i++) begin
            addr = (i < 2) ? 11'h000 : 11'($random(seed) & 7);
            {ce1_n, ce2_n, iord_n} = {i[0], ~i[0], 1'b0};
            expect_v(0, i[0] ? 16'h0006 : 16'h0005);
            expect_v(1, {13'h0000, addr[2:0]});
            expect_v(8, (i[0] || addr[2:0] != 3'h0) ? 16'h00FF : 16'hFFFF);
            step();
        end
        {ce1_n, ce2_n, iord_n, iowr_n} = 4'h6;
        addr = 11'h003;
        d_in = 16'($random(seed));
        expect_v(0, 16'h0005);
        expect_v(11, d_in);
        expect_v(12, 16'h0001);
        step();
        {ce1_n, ce2_n, iord_n, iowr_n} = 4'hF;
        {dma_en, dev_sel, pend} = 3'h7;
        expect_v(7, 16'h0001);
        for (k = 0; k < 2; k++) begin
            dly = 4'(k * 3);
            for (i = 0; dmarq !== 1'b1 && i < 20; i++) step();
            if (i == 20) timed_out();
            for (i = 0; dmack_n !== 1'b0 && i < 20; i++) step();
            if (i == 20) timed_out();
            iord_n = 1'b0;
            expect_v(6, 16'h0000);
            expect_v(8, 16'hFFFF);
            step();
            iord_n = 1'b1;
            step();
        end
        {dma_en, pend} = 2'h1;
        for (i = 0; i < 3; i++) begin
            expect_v(6, 16'h0000);
            step();
        end
        {pend, dev_sel} = 2'h0;
        expect_v(7, 16'h0000);
        repeat (4) step();
        report_and_stop();
    end
endmodule : testbench
